// >>> vocfg_pkg.sv
// vocfg_pkg: register map, field layout and encodings for the converter config bank
// assumes a command-coded register port driven by the PMBus protocol engine on clk_sys
package vocfg_pkg;
	// command codes of the three registers
	localparam logic [7:0]  CMD_INPUT_STOP  = 8'h36;
	localparam logic [7:0]  CMD_CUR_OFFSET  = 8'h39;
	localparam logic [7:0]  CMD_OV_LIMIT    = 8'h40;
	// fixed exponent fields
	localparam logic [4:0]  EXP_INPUT_STOP  = 5'h00;
	localparam logic [4:0]  EXP_CUR_OFFSET  = 5'h1E;
	// field positions
	localparam int          EXP_LSB         = 11;
	localparam int          MANT_MSB        = 3;
	localparam int          OV_FIELD_MSB    = 10;
	// default reset values used only until the nvm restore lands
	localparam logic [3:0]  RST_INPUT_STOP  = 4'h0;
	localparam logic [3:0]  RST_CUR_OFFSET  = 4'h0;
	localparam logic [10:0] RST_OV_LIMIT    = 11'h000;
	// overvoltage field breakpoints
	localparam logic [10:0] OV_BP_16        = 11'd584;
	localparam logic [10:0] OV_BP_20        = 11'd604;
	localparam logic [10:0] OV_BP_50        = 11'd666;
	// input stop thresholds in millivolts
	localparam logic [15:0] VSTOP_9V5       = 16'd9500;
	localparam logic [15:0] VSTOP_8V5       = 16'd8500;
	localparam logic [15:0] VSTOP_7V5       = 16'd7500;
	localparam logic [15:0] VSTOP_6V5       = 16'd6500;
	localparam logic [15:0] VSTOP_5V5       = 16'd5500;
	localparam logic [15:0] VSTOP_4V2       = 16'd4200;
	localparam logic [15:0] VSTOP_3V6       = 16'd3600;
	localparam logic [15:0] VSTOP_2V3       = 16'd2300;
	// overvoltage margins in percent
	localparam logic [7:0]  MARGIN_12       = 8'd12;
	localparam logic [7:0]  MARGIN_16       = 8'd16;
	localparam logic [7:0]  MARGIN_20       = 8'd20;
	localparam logic [7:0]  MARGIN_50       = 8'd50;
	localparam logic [7:0]  PERCENT_FULL    = 8'd100;
	// overvoltage fault action codes (bit 7 enables shutdown, low ignores)
	typedef enum logic [1:0] {VOCFG_ACT_IGNORE = 2'h0, VOCFG_ACT_LATCH = 2'h1, VOCFG_ACT_RETRY = 2'h2} vocfg_act_e;
	// register port request
	typedef struct packed {
		logic        wrEn;
		logic        rdEn;
		logic [7:0]  cmd;
		logic [15:0] wdata;
	} vocfg_req_s;
	// analog measurements, all in mV or mA
	typedef struct packed {
		logic [15:0] inputMv;
		logic [15:0] outputMv;
		logic [15:0] targetMv;
		logic signed [15:0] currentMa;
	} vocfg_meas_s;
endpackage

// >>> vocfg_regs.sv
// vocfg_regs: input stop, current offset and overvoltage limit registers with their checks
// assumes all inputs are synchronous to clk_sys and nvm restore pulses once after reset
`timescale 1ns/10ps
module vocfg_regs
(
	input  wire logic               clk_sys,
	input  wire logic               reset,
	input  vocfg_pkg::vocfg_req_s   req,
	output logic [15:0]             rdData,
	output logic                    rdValid,
	input  wire logic               nvmLoad,
	input  wire logic [3:0]         nvmInputStop,
	input  wire logic [3:0]         nvmCurOffset,
	input  wire logic [10:0]        nvmOvLimit,
	input  vocfg_pkg::vocfg_meas_s  meas,
	input  wire logic [15:0]        startThresholdMv,
	input  wire logic               convEnableCond,
	input  wire logic               softStartDone,
	input  wire logic [7:0]         overvoltFaultAction,
	output logic                    convRun,
	output logic                    inputUndervoltFaultFlag,
	input  wire logic               clearFaults,
	output logic [15:0]             reportedCurrentMa,
	output logic                    overvoltFault,
	output logic                    overvoltShutdown,
	output logic                    overvoltRetry
);
	import vocfg_pkg::*;

	logic [3:0]  stopMant_reg;
	logic [3:0]  offMant_reg;
	logic [10:0] ovLimit_reg;
	logic        uvArmed_reg;
	logic [15:0] stopMv;
	logic [7:0]  marginPct;
	logic [31:0] ovThreshMv;
	logic signed [17:0] sumMa;
	logic        uvEvent;
	logic        ovEvent;

	// register writes; nvm restore has priority since it only runs at start-up
	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			stopMant_reg <= RST_INPUT_STOP;
			offMant_reg  <= RST_CUR_OFFSET;
			ovLimit_reg  <= RST_OV_LIMIT;
		end
		else if (nvmLoad)
		begin
			stopMant_reg <= nvmInputStop;
			offMant_reg  <= nvmCurOffset;
			ovLimit_reg  <= nvmOvLimit;
		end
		else if (req.wrEn)
		begin
			case (req.cmd)
				CMD_INPUT_STOP: stopMant_reg <= req.wdata[MANT_MSB:0];
				CMD_CUR_OFFSET: offMant_reg  <= req.wdata[MANT_MSB:0];
				CMD_OV_LIMIT:   ovLimit_reg  <= req.wdata[OV_FIELD_MSB:0];
				default: ;
			endcase
		end
	end

	// writes land on the next edge; a restore in the same cycle outranks the host
	chk_write_apply: assert property (@(posedge clk_sys) disable iff (reset)
		req.wrEn && !nvmLoad && req.cmd == CMD_INPUT_STOP |=> stopMant_reg == $past(req.wdata[MANT_MSB:0]))
		else $error("write not applied");
	chk_offset_write: assert property (@(posedge clk_sys) disable iff (reset)
		req.wrEn && !nvmLoad && req.cmd == CMD_CUR_OFFSET |=> offMant_reg == $past(req.wdata[MANT_MSB:0]))
		else $error("offset write not applied");
	chk_limit_write: assert property (@(posedge clk_sys) disable iff (reset)
		req.wrEn && !nvmLoad && req.cmd == CMD_OV_LIMIT |=> ovLimit_reg == $past(req.wdata[OV_FIELD_MSB:0]))
		else $error("limit write not applied");
	chk_nvm_restore: assert property (@(posedge clk_sys) disable iff (reset)
		nvmLoad |=> stopMant_reg == $past(nvmInputStop) && offMant_reg == $past(nvmCurOffset)
			&& ovLimit_reg == $past(nvmOvLimit))
		else $error("nvm restore lost");

	// readback builds fixed fields on the fly; unmapped codes read zero
	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			rdData  <= 16'h0000;
			rdValid <= 1'b0;
		end
		else
		begin
			rdValid <= req.rdEn;
			if (req.rdEn)
			begin
				case (req.cmd)
					CMD_INPUT_STOP: rdData <= {EXP_INPUT_STOP, 7'h00, stopMant_reg};
					CMD_CUR_OFFSET: rdData <= {EXP_CUR_OFFSET, {7{offMant_reg[MANT_MSB]}}, offMant_reg};
					CMD_OV_LIMIT:   rdData <= {5'h00, ovLimit_reg};
					default:        rdData <= 16'h0000;
				endcase
			end
		end
	end

	// each read answers one edge later; fixed fields come from constants, not storage
	chk_stop_read: assert property (@(posedge clk_sys) disable iff (reset)
		req.rdEn && req.cmd == CMD_INPUT_STOP |=> rdValid && rdData[15:4] == 12'h000)
		else $error("stop fixed bits");
	chk_stop_mant: assert property (@(posedge clk_sys) disable iff (reset)
		req.rdEn && req.cmd == CMD_INPUT_STOP |=> rdData[MANT_MSB:0] == $past(stopMant_reg))
		else $error("stop mantissa readback");
	chk_offset_sign: assert property (@(posedge clk_sys) disable iff (reset)
		req.rdEn && req.cmd == CMD_CUR_OFFSET |=> rdData[15:EXP_LSB] == EXP_CUR_OFFSET
			&& rdData[10:4] == {7{rdData[MANT_MSB]}})
		else $error("offset sign ext");
	chk_offset_mant: assert property (@(posedge clk_sys) disable iff (reset)
		req.rdEn && req.cmd == CMD_CUR_OFFSET |=> rdData[MANT_MSB:0] == $past(offMant_reg))
		else $error("offset mantissa readback");
	chk_ov_read: assert property (@(posedge clk_sys) disable iff (reset)
		req.rdEn && req.cmd == CMD_OV_LIMIT |=> rdData[15:EXP_LSB] == 5'h00)
		else $error("limit reserved bits");
	chk_limit_mant: assert property (@(posedge clk_sys) disable iff (reset)
		req.rdEn && req.cmd == CMD_OV_LIMIT |=> rdData[OV_FIELD_MSB:0] == $past(ovLimit_reg))
		else $error("limit readback");

	// stop threshold table; decoded live so a write takes effect next cycle
	always_comb
	begin
		if (stopMant_reg >= 4'hA)
			stopMv = VSTOP_9V5;
		else if (stopMant_reg == 4'h9)
			stopMv = VSTOP_8V5;
		else if (stopMant_reg == 4'h8)
			stopMv = VSTOP_7V5;
		else if (stopMant_reg == 4'h7)
			stopMv = VSTOP_6V5;
		else if (stopMant_reg == 4'h6)
			stopMv = VSTOP_5V5;
		else if (stopMant_reg == 4'h5)
			stopMv = VSTOP_4V2;
		else if (stopMant_reg >= 4'h3)
			stopMv = VSTOP_3V6;
		else
			stopMv = VSTOP_2V3;
	end

	// spot checks on the stop table: both ends and the uneven steps
	chk_stop_top: assert property (@(posedge clk_sys) disable iff (reset)
		stopMant_reg >= 4'hA |-> stopMv == VSTOP_9V5)
		else $error("stop decode top");
	chk_stop_6v5: assert property (@(posedge clk_sys) disable iff (reset)
		stopMant_reg == 4'h7 |-> stopMv == VSTOP_6V5)
		else $error("stop decode 6v5");
	chk_stop_4v2: assert property (@(posedge clk_sys) disable iff (reset)
		stopMant_reg == 4'h5 |-> stopMv == VSTOP_4V2)
		else $error("stop decode 4v2");
	chk_stop_3v6: assert property (@(posedge clk_sys) disable iff (reset)
		(stopMant_reg == 4'h3 || stopMant_reg == 4'h4) |-> stopMv == VSTOP_3V6)
		else $error("stop decode 3v6");
	chk_stop_bottom: assert property (@(posedge clk_sys) disable iff (reset)
		stopMant_reg <= 4'h2 |-> stopMv == VSTOP_2V3)
		else $error("stop decode bottom");

	// overvoltage margin table and threshold = target * (100 + margin) / 100
	always_comb
	begin
		if (ovLimit_reg < OV_BP_16)
			marginPct = MARGIN_12;
		else if (ovLimit_reg < OV_BP_20)
			marginPct = MARGIN_16;
		else if (ovLimit_reg < OV_BP_50)
			marginPct = MARGIN_20;
		else
			marginPct = MARGIN_50;
		ovThreshMv = (32'(meas.targetMv) * (32'(PERCENT_FULL) + 32'(marginPct))) / 32'(PERCENT_FULL);
	end

	// margin bands, each checked against its breakpoints
	chk_margin_low: assert property (@(posedge clk_sys) disable iff (reset)
		ovLimit_reg < OV_BP_16 |-> marginPct == MARGIN_12)
		else $error("margin decode low");
	chk_margin_mid: assert property (@(posedge clk_sys) disable iff (reset)
		ovLimit_reg >= OV_BP_16 && ovLimit_reg < OV_BP_20 |-> marginPct == MARGIN_16)
		else $error("margin decode mid");
	chk_margin_high: assert property (@(posedge clk_sys) disable iff (reset)
		ovLimit_reg >= OV_BP_20 && ovLimit_reg < OV_BP_50 |-> marginPct == MARGIN_20)
		else $error("margin decode high");
	chk_ov_margin: assert property (@(posedge clk_sys) disable iff (reset)
		ovLimit_reg >= OV_BP_50 |-> marginPct == MARGIN_50)
		else $error("margin decode");

	// the start/stop ordering is the host's job; a stop above start simply chatters
	assign uvEvent = uvArmed_reg && convEnableCond && (meas.inputMv < stopMv);
	assign ovEvent = softStartDone && (32'(meas.outputMv) > ovThreshMv);

	// both events are gated, so the guards are checked on the flags they feed
	chk_uv_masked: assert property (@(posedge clk_sys) disable iff (reset)
		!uvArmed_reg |=> !inputUndervoltFaultFlag)
		else $error("undervolt before arming");
	chk_ov_armed: assert property (@(posedge clk_sys) disable iff (reset)
		!softStartDone && !overvoltFault |=> !overvoltFault)
		else $error("ov active during soft-start");
	chk_uv_enabled: assert property (@(posedge clk_sys) disable iff (reset)
		!convEnableCond && !inputUndervoltFaultFlag |=> !inputUndervoltFaultFlag)
		else $error("undervolt while disabled");

	// undervolt mask opens once per power-on; enable and nvm traffic leave it alone
	always_ff @(posedge clk_sys)
	begin
		if (reset)
			uvArmed_reg <= 1'b0;
		else if (meas.inputMv > startThresholdMv)
			uvArmed_reg <= 1'b1;
	end

	// once open the mask never closes again short of a reset
	chk_arm_sticky: assert property (@(posedge clk_sys) disable iff (reset)
		uvArmed_reg |=> uvArmed_reg)
		else $error("undervolt mask closed again");

	// conversion gate and sticky undervolt flag; a new event beats a clear
	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			convRun                 <= 1'b0;
			inputUndervoltFaultFlag <= 1'b0;
		end
		else
		begin
			convRun <= convEnableCond && !uvEvent && !overvoltShutdown;
			if (uvEvent)
				inputUndervoltFaultFlag <= 1'b1;
			else if (clearFaults)
				inputUndervoltFaultFlag <= 1'b0;
		end
	end

	// undervolt: flag and halt on the next edge, clear only when no event is live
	chk_uv_flag_set: assert property (@(posedge clk_sys) disable iff (reset)
		uvEvent |=> inputUndervoltFaultFlag && !convRun)
		else $error("undervolt not flagged");
	chk_uv_clear: assert property (@(posedge clk_sys) disable iff (reset)
		clearFaults && !uvEvent |=> !inputUndervoltFaultFlag)
		else $error("undervolt flag not cleared");
	chk_run_enable: assert property (@(posedge clk_sys) disable iff (reset)
		!convEnableCond |=> !convRun)
		else $error("running while disabled");

	// overvoltage fault: sticky flag, action chosen by bit 7 and retry bit 5
	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			overvoltFault    <= 1'b0;
			overvoltShutdown <= 1'b0;
			overvoltRetry    <= 1'b0;
		end
		else
		begin
			if (ovEvent)
				overvoltFault <= 1'b1;
			else if (clearFaults)
				overvoltFault <= 1'b0;
			// a live event beats a clear; a stored fault is acted on if shutdown
			// gets enabled before the host clears it, but a clear always wins over it
			if (ovEvent && overvoltFaultAction[7])
			begin
				overvoltShutdown <= 1'b1;
				overvoltRetry    <= overvoltFaultAction[5];
			end
			else if (clearFaults || !convEnableCond)
			begin
				overvoltShutdown <= 1'b0;
				overvoltRetry    <= 1'b0;
			end
			else if (overvoltFault && overvoltFaultAction[7])
			begin
				overvoltShutdown <= 1'b1;
				overvoltRetry    <= overvoltFaultAction[5];
			end
		end
	end

	// overvoltage: flag, chosen action, and the way back out through a clear
	chk_ov_action: assert property (@(posedge clk_sys) disable iff (reset)
		ovEvent && overvoltFaultAction[7] |=> overvoltShutdown ##1 !convRun)
		else $error("ov shutdown missed");
	chk_ov_flag_set: assert property (@(posedge clk_sys) disable iff (reset)
		ovEvent |=> overvoltFault)
		else $error("ov not flagged");
	chk_ov_retry: assert property (@(posedge clk_sys) disable iff (reset)
		ovEvent && overvoltFaultAction[7] |=> overvoltRetry == $past(overvoltFaultAction[5]))
		else $error("ov retry choice lost");
	chk_ov_clear: assert property (@(posedge clk_sys) disable iff (reset)
		clearFaults && !ovEvent |=> !overvoltFault && !overvoltShutdown)
		else $error("ov fault not cleared");
	chk_ov_ignored: assert property (@(posedge clk_sys) disable iff (reset)
		!overvoltShutdown && !overvoltFaultAction[7] |=> !overvoltShutdown)
		else $error("ov shutdown while ignoring");

	// current report: signed add at quarter-amp weight, floor at zero
	assign sumMa = 18'($signed(meas.currentMa)) + 18'($signed(offMant_reg)) * 18'sd250;

	always_ff @(posedge clk_sys)
	begin
		if (reset)
			reportedCurrentMa <= 16'h0000;
		else if (sumMa < 0)
			reportedCurrentMa <= 16'h0000;
		else if (sumMa > 18'sd32767)
			reportedCurrentMa <= 16'h7FFF;
		else
			reportedCurrentMa <= sumMa[15:0];
	end

	// current report: floor, pass-through and ceiling
	chk_clamp_floor: assert property (@(posedge clk_sys) disable iff (reset)
		sumMa < 0 |=> reportedCurrentMa == 16'h0000)
		else $error("current not clamped");
	chk_current_pass: assert property (@(posedge clk_sys) disable iff (reset)
		sumMa >= 0 && sumMa <= 18'sd32767 |=> reportedCurrentMa == $past(sumMa[15:0]))
		else $error("current offset not applied");
	chk_current_sat: assert property (@(posedge clk_sys) disable iff (reset)
		sumMa > 18'sd32767 |=> reportedCurrentMa == 16'h7FFF)
		else $error("current not saturated");
endmodule

// >>> vocfg_host_model.sv
// vocfg_host_model: host side of the register port, issues whole 16-bit writes and reads
// assumes tb_top owns error_cnt and test_done for a read that never answers
`timescale 1ns/10ps
module vocfg_host_model
(
	input  wire logic              clk_sys,
	output vocfg_pkg::vocfg_req_s  req,
	input  wire logic [15:0]       rdData,
	input  wire logic              rdValid
);
	import vocfg_pkg::*;
	initial req = '0;
	// request launched after an edge, dropped after the taking edge so it is seen exactly once
	task automatic wr(input logic [7:0] c, input logic [15:0] d);
		@(posedge clk_sys);
		req <= '{1'b1, 1'b0, c, d};
		@(posedge clk_sys);
		req <= '0;
	endtask
	// the answer is a one-cycle pulse, so it is looked at just after every edge
	task automatic rd(input logic [7:0] c, output logic [15:0] d);
		int i;
		@(posedge clk_sys);
		req <= '{1'b0, 1'b1, c, 16'h0000};
		@(posedge clk_sys);
		req <= '0;
		d = 16'h0000;
		for (i = 0; i < 4; i++)
		begin
			#1;
			if (rdValid === 1'b1)
			begin
				d = rdData;
				return;
			end
			@(posedge clk_sys);
		end
		tb_top.error_cnt++;
		tb_top.test_done();
	endtask
endmodule

// >>> tb_top.sv
// tb_top: self-checking bench for the converter config register bank
// assumes one 100 MHz clock and the host model on the register port
`timescale 1ns/10ps
module tb_top;
	import vocfg_pkg::*;
	logic        clk_sys = 1'b0;
	logic        reset = 1'b1;
	vocfg_req_s  req;
	vocfg_meas_s meas = '0;
	logic [15:0] rdData, curMa, r;
	logic [15:0] startMv = 16'h2710; // start kept above every stop setting, as the host should
	logic        rdValid, run, uvFlag, ovFault, ovShut, ovRetry;
	logic        nvmLoad = 1'b0, enable = 1'b0, ssDone = 1'b0, clr = 1'b0;
	logic [7:0]  ovAction = 8'h00;
	int          error_cnt = 0;
	int          num_checks = 0;

	always #5 clk_sys = ~clk_sys;

	// nvm values are fixed: one restore is enough to see every field land
	vocfg_regs vocfg_regs_inst (.clk_sys(clk_sys), .reset(reset), .req(req), .rdData(rdData),
		.rdValid(rdValid), .nvmLoad(nvmLoad), .nvmInputStop(4'h5), .nvmCurOffset(4'h3),
		.nvmOvLimit(11'h258), .meas(meas), .startThresholdMv(startMv), .convEnableCond(enable),
		.softStartDone(ssDone), .overvoltFaultAction(ovAction), .convRun(run),
		.inputUndervoltFaultFlag(uvFlag), .clearFaults(clr), .reportedCurrentMa(curMa),
		.overvoltFault(ovFault), .overvoltShutdown(ovShut), .overvoltRetry(ovRetry));
	vocfg_host_model vocfg_host_model_inst (.clk_sys(clk_sys), .req(req), .rdData(rdData),
		.rdValid(rdValid));

	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		num_checks++;
		if (g !== e)
		begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic chkBit(input string n, input logic e, input logic g);
		chk(n, {15'h0000, e}, {15'h0000, g});
	endtask
	task automatic test_done();
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// outputs are registered behind combinational decode, three edges covers the one or two register stages
	task automatic settle();
		repeat (3) @(posedge clk_sys);
		#1;
	endtask
	task automatic rdChk(input string n, input logic [7:0] c, input logic [15:0] e);
		vocfg_host_model_inst.rd(c, r);
		chk(n, e, r);
	endtask
	// clear one edge after the stimulus drops, since a live event beats the clear
	task automatic clearAll();
		@(posedge clk_sys);
		clr <= 1'b1;
		@(posedge clk_sys);
		clr <= 1'b0;
	endtask

	task automatic regScenario();
		rdChk("stop", CMD_INPUT_STOP, 16'h0005);
		rdChk("offset", CMD_CUR_OFFSET, 16'hF003);
		rdChk("ovlim", CMD_OV_LIMIT, 16'h0258);
		vocfg_host_model_inst.wr(CMD_INPUT_STOP, 16'hFFFF);
		rdChk("stop", CMD_INPUT_STOP, 16'h000F);
		vocfg_host_model_inst.wr(CMD_OV_LIMIT, 16'hFFFF);
		rdChk("ovlim", CMD_OV_LIMIT, 16'h07FF);
		rdChk("unmapped", 8'h37, 16'h0000);
	endtask

	task automatic currentScenario();
		@(posedge clk_sys);
		meas.currentMa <= 16'sh03E8;
		vocfg_host_model_inst.wr(CMD_CUR_OFFSET, 16'h0008);
		rdChk("offset", CMD_CUR_OFFSET, 16'hF7F8);
		settle();
		chk("current", 16'h0000, curMa);
		vocfg_host_model_inst.wr(CMD_CUR_OFFSET, 16'h0007);
		rdChk("offset", CMD_CUR_OFFSET, 16'hF007);
		settle();
		chk("current", 16'h0ABE, curMa);
	endtask

	task automatic undervoltScenario();
		int i;
		logic [3:0]  m [8] = '{4'hF, 4'h9, 4'h8, 4'h7, 4'h6, 4'h5, 4'h4, 4'h0};
		logic [15:0] v [8] = '{VSTOP_9V5, VSTOP_8V5, VSTOP_7V5, VSTOP_6V5, VSTOP_5V5, VSTOP_4V2,
			VSTOP_3V6, VSTOP_2V3};
		@(posedge clk_sys);
		enable <= 1'b1;
		meas.inputMv <= 16'h0BB8;
		settle();
		chkBit("uvflag", 1'b0, uvFlag);
		@(posedge clk_sys);
		meas.inputMv <= 16'h2904;
		for (i = 0; i < 8; i++)
		begin
			vocfg_host_model_inst.wr(CMD_INPUT_STOP, {12'h000, m[i]});
			@(posedge clk_sys);
			meas.inputMv <= v[i];
			settle();
			chkBit("uvflag", 1'b0, uvFlag);
			@(posedge clk_sys);
			meas.inputMv <= v[i] - 16'h0001;
			settle();
			chkBit("uvflag", 1'b1, uvFlag);
			chkBit("run", 1'b0, run);
			@(posedge clk_sys);
			meas.inputMv <= 16'h2904;
			clearAll();
		end
	endtask

	task automatic overvoltScenario();
		int i;
		logic [10:0] f [4] = '{11'h247, 11'h248, 11'h25C, 11'h29A};
		logic [15:0] t [4] = '{16'h0460, 16'h0488, 16'h04B0, 16'h05DC};
		@(posedge clk_sys);
		meas.targetMv <= 16'h03E8;
		meas.outputMv <= 16'h07D0;
		settle();
		chkBit("ovfault", 1'b0, ovFault);
		for (i = 0; i < 4; i++)
		begin
			vocfg_host_model_inst.wr(CMD_OV_LIMIT, {5'h00, f[i]});
			@(posedge clk_sys);
			ssDone <= 1'b1;
			ovAction <= (i == 0) ? 8'h00 : ((i == 3) ? 8'hA0 : 8'h80);
			meas.outputMv <= t[i];
			settle();
			chkBit("ovfault", 1'b0, ovFault);
			@(posedge clk_sys);
			meas.outputMv <= t[i] + 16'h0001;
			settle();
			chkBit("ovfault", 1'b1, ovFault);
			chkBit("ovshut", i != 0, ovShut);
			chkBit("ovretry", i == 3, ovRetry);
			@(posedge clk_sys);
			meas.outputMv <= 16'h03E8;
			clearAll();
			settle();
			chkBit("ovshut", 1'b0, ovShut);
		end
	endtask

	// the undervolt scenario opens the mask itself before any trip is looked for
	initial
	begin
		repeat (12) @(posedge clk_sys);
		reset <= 1'b0;
		@(posedge clk_sys);
		nvmLoad <= 1'b1;
		@(posedge clk_sys);
		nvmLoad <= 1'b0;
		regScenario();
		currentScenario();
		undervoltScenario();
		overvoltScenario();
		test_done();
	end
endmodule
